// ==== rtl/lcdra_core.sv ====
// Overview of operation
// R1 - glyph address set loads six bits
// R2 - char address set loads seven bits
// R3 - one-line char range 00 to 4F
// R4 - two-line ranges 00-27 and 40-67
// R5 - instruction read returns busy and counter
// R6 - host waits while busy is high
// R7 - data write stores into selected ram
// R8 - data write steps the address counter
// R9 - data reads refused over serial interfaces
// R10 - host discards first read without address set
// R11 - cursor shift reloads the output data register
// R12 - data read steps the address counter
// R13 - host avoids display shift after glyph read
// R14 - read after write returns old latched data
// R15 - entry direction picks step up or down
// R16 - line-count bit selects one or two lines
// R17 - serial host sets bus width bit
// R18 - target flag remembers the selected ram
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module lcdra_core
   import lcdra_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic busy_flag,
   output logic [6:0] address_counter
);

   lcdra_state_t st;
   lcdra_state_t next_st;
   lcdra_ram_wr_t glyph_wr;
   lcdra_ram_wr_t char_wr;
   logic [7:0] glyph_rd;
   logic [7:0] char_rd;
   logic [7:0] ram_rd;
   logic [6:0] stepped_ac;
   logic step_up;
   logic wr_en;
   logic rd_en;
   logic mapped;
   logic is_shift;
   logic cursor_shift;
   logic serial_read;

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign mapped = (paddr == OFS_INSTR) || (paddr == OFS_DATA) ||
                   (paddr == OFS_CTRL) || (paddr == OFS_STATUS);
   assign is_shift = pwdata[7:4] == INSTR_SHIFT_CODE;
   assign cursor_shift = wr_en && paddr == OFS_INSTR && is_shift &&
                         !pwdata[INSTR_SHIFT_DISPLAY_BIT];
   // serial links cannot return ram data, so such a read is an error
   assign serial_read = rd_en && paddr == OFS_DATA && st.ctrl[CTRL_SERIAL_BIT];
   assign busy_flag = st.busy_cnt != '0;
   assign address_counter = st.ac;
   // zero wait states: every request completes in its first access cycle
   assign pready = 1'b1;
   assign pslverr = psel && penable &&
                    (!mapped || serial_read || (pwrite && paddr == OFS_STATUS)); // R9

   // ------------------------------------------------------------
   // address stepping and ram
   // ------------------------------------------------------------
   assign step_up = cursor_shift ? pwdata[INSTR_SHIFT_RIGHT_BIT] : st.ctrl[CTRL_INC_BIT]; // R15

   lcdra_addr_step u_step (
      .addr(st.ac),
      .up(step_up),
      .two_line(st.ctrl[CTRL_TWO_LINE_BIT]),
      .glyph(st.target == TGT_GLYPH),
      .next_addr(stepped_ac)
   );

   lcdra_ram #(.DEPTH(GLYPH_DEPTH), .AW(6), .W(8)) u_glyph_ram (
      .pclk(pclk),
      .presetn(presetn),
      .wr(glyph_wr),
      .rd_addr(st.ac[5:0]),
      .rd_data(glyph_rd)
   );

   lcdra_ram #(.DEPTH(CHAR_DEPTH), .AW(7), .W(8)) u_char_code_ram (
      .pclk(pclk),
      .presetn(presetn),
      .wr(char_wr),
      .rd_addr(st.ac),
      .rd_data(char_rd)
   );

   assign ram_rd = (st.target == TGT_GLYPH) ? glyph_rd : char_rd;

   // ------------------------------------------------------------
   // instruction and data handling
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      glyph_wr = '0;
      char_wr = '0;
      if (st.busy_cnt != '0) begin
         next_st.busy_cnt = BUSY_W'(st.busy_cnt - 1'b1);
      end
      // output data register is filled one cycle after the counter moves
      if (st.refill) begin
         next_st.dout = ram_rd;
         next_st.refill = 1'b0;
      end
      if (wr_en) begin
         unique case (paddr)
            OFS_INSTR: begin
               next_st.busy_cnt = EXEC_COUNT;
               if (pwdata[INSTR_CHAR_SET_BIT]) begin
                  next_st.ac = pwdata[6:0]; // R2
                  next_st.target = TGT_CHAR; // R18
                  next_st.refill = 1'b1;
               end else if (pwdata[7:6] == INSTR_GLYPH_SET_CODE) begin
                  next_st.ac = {1'b0, pwdata[5:0]}; // R1
                  next_st.target = TGT_GLYPH; // R18
                  next_st.refill = 1'b1;
               end else if (cursor_shift) begin
                  next_st.ac = stepped_ac; // R11
                  next_st.refill = 1'b1; // R11
               end
            end
            OFS_DATA: begin
               next_st.busy_cnt = EXEC_COUNT;
               if (st.target == TGT_GLYPH) begin
                  glyph_wr = '{we: 1'b1, addr: st.ac, data: pwdata[7:0]}; // R7
               end else begin
                  char_wr = '{we: 1'b1, addr: st.ac, data: pwdata[7:0]}; // R7
               end
               // dout is left alone, so a following read sees old data
               next_st.ac = stepped_ac; // R8 R14
            end
            OFS_CTRL: begin
               next_st.ctrl = pwdata[3:0]; // R16
            end
            default: begin
            end
         endcase
      end
      if (rd_en && paddr == OFS_DATA && !serial_read) begin
         next_st.ac = stepped_ac; // R12
         next_st.refill = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '{ac: '0, target: TGT_CHAR, dout: '0, refill: 1'b0,
                 busy_cnt: '0, ctrl: CTRL_RESET};
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   always_comb begin
      prdata = '0;
      if (rd_en) begin
         unique case (paddr)
            OFS_INSTR: prdata[7:0] = {busy_flag, st.ac}; // R5
            OFS_DATA: prdata[7:0] = serial_read ? 8'h00 : st.dout; // R14
            OFS_CTRL: prdata[3:0] = st.ctrl;
            OFS_STATUS: prdata[9:0] = {st.refill, st.target == TGT_GLYPH, busy_flag, st.ac};
            default: prdata = '0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic data_wr;
   logic data_rd;
   assign data_wr = wr_en && paddr == OFS_DATA;
   assign data_rd = rd_en && paddr == OFS_DATA && !serial_read;

   AST_GLYPH_SET: assert property ( // R1
      wr_en && paddr == OFS_INSTR && pwdata[7:6] == INSTR_GLYPH_SET_CODE
      |=> st.ac == {1'b0, $past(pwdata[5:0])} && st.target == TGT_GLYPH ##1 st.dout == $past(ram_rd))
      else $error("glyph address set not applied");

   AST_CHAR_SET: assert property ( // R2
      wr_en && paddr == OFS_INSTR && pwdata[INSTR_CHAR_SET_BIT]
      |=> st.ac == $past(pwdata[6:0]) && st.target == TGT_CHAR && busy_flag)
      else $error("char address set not applied");

   AST_ONE_LINE_WRAP: assert property ( // R3
      data_wr && st.target == TGT_CHAR && !st.ctrl[CTRL_TWO_LINE_BIT] &&
      st.ctrl[CTRL_INC_BIT] && st.ac == CHAR_ONE_LINE_LAST |=> st.ac == CHAR_FIRST)
      else $error("one-line counter did not wrap");

   AST_TWO_LINE_JUMP: assert property ( // R4
      data_wr && st.target == TGT_CHAR && st.ctrl[CTRL_TWO_LINE_BIT] &&
      st.ctrl[CTRL_INC_BIT] && st.ac == CHAR_LINE1_LAST |=> st.ac == CHAR_LINE2_FIRST)
      else $error("two-line counter did not jump to line two");

   AST_STATUS_READ: assert property ( // R5
      rd_en && paddr == OFS_INSTR |-> prdata[7:0] == {st.busy_cnt != '0, st.ac})
      else $error("busy and counter read wrong");

   AST_DATA_WRITE: assert property ( // R7
      data_wr |-> (glyph_wr.we || char_wr.we) && (glyph_wr.we == (st.target == TGT_GLYPH))
      && (glyph_wr.we ? glyph_wr.addr : char_wr.addr) == st.ac)
      else $error("data write went to wrong ram or address");

   AST_WRITE_STEP: assert property ( // R8
      data_wr && st.target == TGT_GLYPH && st.ctrl[CTRL_INC_BIT]
      |=> st.ac[5:0] == 6'($past(st.ac[5:0]) + 6'h01))
      else $error("counter not incremented after write");

   AST_DOWN_STEP: assert property ( // R15
      data_wr && st.target == TGT_CHAR && !st.ctrl[CTRL_INC_BIT] &&
      !st.ctrl[CTRL_TWO_LINE_BIT] && st.ac != CHAR_FIRST |=> st.ac == 7'($past(st.ac) - 7'h01))
      else $error("counter not decremented");

   AST_READ_STEP: assert property ( // R12
      data_rd |=> st.ac == $past(stepped_ac) && st.refill ##1 st.dout == $past(ram_rd))
      else $error("read did not step and refill");

   AST_SERIAL_READ: assert property ( // R9
      serial_read |-> pslverr ##1 st.ac == $past(st.ac) && !st.refill)
      else $error("serial data read not refused");

   AST_WRITE_KEEPS_DOUT: assert property ( // R14
      data_wr && !st.refill |=> st.dout == $past(st.dout))
      else $error("write disturbed latched data");

   AST_SHIFT_REFILL: assert property ( // R11
      cursor_shift |=> st.refill ##1 st.dout == $past(ram_rd))
      else $error("cursor shift did not reload output data");

   // busy is reloaded by every instruction or data write, never by reads
   AST_WRITE_BUSY: assert property ( // R5
      data_wr |=> busy_flag && st.busy_cnt == EXEC_COUNT)
      else $error("data write did not start busy");

   AST_TARGET_HOLD: assert property ( // R18
      !(wr_en && paddr == OFS_INSTR) |=> st.target == $past(st.target))
      else $error("target changed without address set");

   AST_UP_STEP: assert property ( // R8
      data_wr && st.target == TGT_CHAR && st.ctrl[CTRL_INC_BIT] &&
      !st.ctrl[CTRL_TWO_LINE_BIT] && st.ac != CHAR_ONE_LINE_LAST
      |=> st.ac == 7'($past(st.ac) + 7'h01))
      else $error("counter not incremented after char write");

   AST_TWO_LINE_BACK: assert property ( // R4
      data_wr && st.target == TGT_CHAR && st.ctrl[CTRL_TWO_LINE_BIT] &&
      !st.ctrl[CTRL_INC_BIT] && st.ac == CHAR_LINE2_FIRST |=> st.ac == CHAR_LINE1_LAST)
      else $error("two-line counter did not step back to line one");

   AST_TWO_LINE_END: assert property ( // R4
      data_wr && st.target == TGT_CHAR && st.ctrl[CTRL_TWO_LINE_BIT] &&
      st.ctrl[CTRL_INC_BIT] && st.ac == CHAR_LINE2_LAST |=> st.ac == CHAR_FIRST)
      else $error("two-line counter did not wrap to line one");

   AST_ONE_LINE_BACK: assert property ( // R3
      data_wr && st.target == TGT_CHAR && !st.ctrl[CTRL_TWO_LINE_BIT] &&
      !st.ctrl[CTRL_INC_BIT] && st.ac == CHAR_FIRST |=> st.ac == CHAR_ONE_LINE_LAST)
      else $error("one-line counter did not wrap downward");

   AST_READ_OLD_DATA: assert property ( // R14
      data_rd |-> prdata[7:0] == st.dout)
      else $error("data read did not return the latched value");

   AST_SHIFT_STEP: assert property ( // R11
      cursor_shift && pwdata[INSTR_SHIFT_RIGHT_BIT] && st.target == TGT_CHAR &&
      !st.ctrl[CTRL_TWO_LINE_BIT] && st.ac != CHAR_ONE_LINE_LAST
      |=> st.ac == 7'($past(st.ac) + 7'h01))
      else $error("cursor shift did not move the counter");

   AST_CTRL_WRITE: assert property ( // R16
      wr_en && paddr == OFS_CTRL |=> st.ctrl == $past(pwdata[3:0]))
      else $error("control write not applied");

   AST_SERIAL_ZERO: assert property ( // R9
      serial_read |-> prdata == '0)
      else $error("serial data read returned data");

   COV_GLYPH_SET: cover property (
      wr_en && paddr == OFS_INSTR && pwdata[7:6] == INSTR_GLYPH_SET_CODE);
   COV_WRITE_THEN_READ: cover property (data_wr ##[1:4] data_rd);
   COV_CURSOR_SHIFT: cover property (cursor_shift);
   COV_LINE_JUMP: cover property (st.ac == CHAR_LINE1_LAST ##1 st.ac == CHAR_LINE2_FIRST);

endmodule : lcdra_core
`default_nettype wire

// ==== include/lcdra_pkg.sv ====
`default_nettype none
package lcdra_pkg;

   // ------------------------------------------------------------
   // register map (byte addresses on the apb)
   // ------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFS_INSTR = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_DATA = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0C;

   // ------------------------------------------------------------
   // control register fields
   // ------------------------------------------------------------
   localparam int CTRL_INC_BIT = 0;
   localparam int CTRL_TWO_LINE_BIT = 1;
   localparam int CTRL_BUS_WIDTH_BIT = 2;
   localparam int CTRL_SERIAL_BIT = 3;
   localparam logic [3:0] CTRL_RESET = 4'h5;

   // ------------------------------------------------------------
   // instruction decode fields
   // ------------------------------------------------------------
   localparam int INSTR_CHAR_SET_BIT = 7;
   localparam logic [1:0] INSTR_GLYPH_SET_CODE = 2'h1;
   localparam logic [3:0] INSTR_SHIFT_CODE = 4'h1;
   localparam int INSTR_SHIFT_DISPLAY_BIT = 3;
   localparam int INSTR_SHIFT_RIGHT_BIT = 2;

   // ------------------------------------------------------------
   // char_code_ram address map
   // ------------------------------------------------------------
   localparam logic [6:0] CHAR_FIRST = 7'h00;
   localparam logic [6:0] CHAR_ONE_LINE_LAST = 7'h4F;
   localparam logic [6:0] CHAR_LINE1_LAST = 7'h27;
   localparam logic [6:0] CHAR_LINE2_FIRST = 7'h40;
   localparam logic [6:0] CHAR_LINE2_LAST = 7'h67;
   localparam int GLYPH_DEPTH = 64;
   localparam int CHAR_DEPTH = 128;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_FREQ_MHZ = 40;
   localparam int EXEC_TIME_NS = 18500;
   localparam int EXEC_CYCLES = (EXEC_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam int BUSY_W = $clog2(EXEC_CYCLES + 1);
   localparam logic [BUSY_W-1:0] EXEC_COUNT = BUSY_W'(EXEC_CYCLES);

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic {TGT_GLYPH, TGT_CHAR} lcdra_target_t;

   typedef struct packed {
      logic we;
      logic [6:0] addr;
      logic [7:0] data;
   } lcdra_ram_wr_t;

   typedef struct packed {
      logic [6:0] ac;
      lcdra_target_t target;
      logic [7:0] dout;
      logic refill;
      logic [BUSY_W-1:0] busy_cnt;
      logic [3:0] ctrl;
   } lcdra_state_t;

endpackage : lcdra_pkg
`default_nettype wire

// ==== rtl/lcdra_addr_step.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcdra_addr_step
   import lcdra_pkg::*;
(
   input wire logic [6:0] addr,
   input wire logic up,
   input wire logic two_line,
   input wire logic glyph,
   output logic [6:0] next_addr
);

   // ------------------------------------------------------------
   // one step of the address counter
   // ------------------------------------------------------------
   always_comb begin
      if (glyph) begin
         next_addr = {1'b0, up ? 6'(addr[5:0] + 6'h01) : 6'(addr[5:0] - 6'h01)};
      end else if (up) begin
         if (two_line && addr == CHAR_LINE1_LAST) begin
            next_addr = CHAR_LINE2_FIRST; // R4
         end else if (two_line && addr == CHAR_LINE2_LAST) begin
            next_addr = CHAR_FIRST; // R4
         end else if (!two_line && addr == CHAR_ONE_LINE_LAST) begin
            next_addr = CHAR_FIRST; // R3
         end else begin
            next_addr = 7'(addr + 7'h01); // R15
         end
      end else begin
         if (two_line && addr == CHAR_FIRST) begin
            next_addr = CHAR_LINE2_LAST; // R4
         end else if (two_line && addr == CHAR_LINE2_FIRST) begin
            next_addr = CHAR_LINE1_LAST; // R4
         end else if (!two_line && addr == CHAR_FIRST) begin
            next_addr = CHAR_ONE_LINE_LAST; // R3
         end else begin
            next_addr = 7'(addr - 7'h01); // R15
         end
      end
   end

endmodule : lcdra_addr_step
`default_nettype wire

// ==== rtl/lcdra_ram.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcdra_ram
   import lcdra_pkg::*;
#(
   parameter int DEPTH = 64,
   parameter int AW = 6,
   parameter int W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire lcdra_ram_wr_t wr,
   input wire logic [AW-1:0] rd_addr,
   output logic [W-1:0] rd_data
);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
   } lcdra_ram_state_t;

   lcdra_ram_state_t st;
   lcdra_ram_state_t next_st;

   // ------------------------------------------------------------
   // flip-flop storage, one write port and one read port
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      if (wr.we) begin
         next_st.mem[wr.addr[AW-1:0]] = wr.data[W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign rd_data = st.mem[rd_addr];

endmodule : lcdra_ram
`default_nettype wire

// ==== sim/lcdra_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcdra_host
   import lcdra_pkg::*;
(
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [ADDR_W-1:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // ------------------------------------------------------------
   // host processor on the apb
   // ------------------------------------------------------------
   logic [31:0] hq;
   logic he;

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end

   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // no limit here: the bench watchdog ends a wait that never completes
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines flip so a stale value cannot pass for a live one
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer

   // poll until not busy before any further instruction
   task automatic wait_idle();
      for (int i = 0; i < 2000; i++) begin
         xfer(1'b0, OFS_INSTR, 32'h0000_0000, hq, he);
         if (hq[7] === 1'b0) break;
      end
   endtask : wait_idle

   task automatic cmd(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, hq, he);
      wait_idle();
   endtask : cmd

   task automatic init();
      xfer(1'b1, OFS_CTRL, 32'h0000_0005, hq, he);
   endtask : init

   // address set precedes the read; no display shift is sent after a glyph read
   task automatic fetch(input logic [7:0] set, output logic [31:0] v);
      cmd(OFS_INSTR, 32'(set));
      xfer(1'b0, OFS_DATA, 32'h0000_0000, v, he);
   endtask : fetch
endmodule : lcdra_host
`default_nettype wire

// ==== sim/lcdra_core_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcdra_core_bench
   import lcdra_pkg::*;
;
   // ------------------------------------------------------------
   // bench top
   // ------------------------------------------------------------
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, busy_flag, e;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [6:0] address_counter;
   logic [23:0] tbl [6] = '{24'h05_4F00, 24'h04_004F, 24'h07_2740,
      24'h07_6700, 24'h06_4027, 24'h06_0067};
   int n_errors = 0;
   int checked = 0;

   always #12.5 pclk = ~pclk;

   lcdra_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .busy_flag(busy_flag), .address_counter(address_counter));

   lcdra_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      checked++;
      if (s !== x) begin
         n_errors++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, s, x);
      end
   endtask : chk

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : print_verdict

   task automatic rd(input logic [ADDR_W-1:0] a);
      u_host.xfer(1'b0, a, 32'h0000_0000, q, e);
   endtask : rd

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      u_host.xfer(1'b1, a, d, q, e);
   endtask : wr

   function automatic logic [31:0] ac();
      return {25'h000_0000, address_counter};
   endfunction : ac

   initial begin
      // generous: about eighty busy periods of 740 cycles
      #(25 * 60000);
      n_errors++;
      print_verdict();
   end

   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd(OFS_STATUS);
      chk(q, 32'h0000_0000);
      rd(OFS_CTRL);
      chk(q, 32'h0000_0005);
      u_host.init();
      wr(OFS_INSTR, 32'h0000_00C5);
      #1 chk({31'h0, busy_flag}, 32'h0000_0001);
      rd(OFS_INSTR);
      chk(q, 32'h0000_00C5);
      u_host.wait_idle();
      chk(ac(), 32'h0000_0045);
      u_host.cmd(OFS_INSTR, 32'h0000_007F);
      rd(OFS_STATUS);
      chk(q, 32'h0000_013F);
      u_host.cmd(OFS_INSTR, 32'h0000_0045);
      u_host.cmd(OFS_DATA, 32'h0000_00AA);
      chk(ac(), 32'h0000_0006);
      u_host.cmd(OFS_DATA, 32'h0000_00BB);
      wr(OFS_CTRL, 32'h0000_0004);
      u_host.cmd(OFS_DATA, 32'h0000_00CC);
      chk(ac(), 32'h0000_0006);
      wr(OFS_CTRL, 32'h0000_0005);
      u_host.fetch(8'h45, q);
      chk(q, 32'h0000_00AA);
      #1 chk(ac(), 32'h0000_0006);
      rd(OFS_DATA);
      chk(q, 32'h0000_00BB);
      rd(OFS_DATA);
      chk(q, 32'h0000_00CC);
      u_host.cmd(OFS_INSTR, 32'h0000_0090);
      u_host.cmd(OFS_DATA, 32'h0000_0011);
      rd(OFS_DATA);
      chk(q, 32'h0000_0000);
      u_host.cmd(OFS_INSTR, 32'h0000_00A0);
      u_host.cmd(OFS_DATA, 32'h0000_005A);
      u_host.cmd(OFS_DATA, 32'h0000_006B);
      u_host.cmd(OFS_INSTR, 32'h0000_00A0);
      u_host.cmd(OFS_INSTR, 32'h0000_0014);
      chk(ac(), 32'h0000_0021);
      rd(OFS_DATA);
      chk(q, 32'h0000_006B);
      for (int i = 0; i < 6; i++) begin
         wr(OFS_CTRL, 32'(tbl[i][23:16]));
         u_host.cmd(OFS_INSTR, 32'(8'h80 | tbl[i][15:8]));
         u_host.cmd(OFS_DATA, 32'h0000_0000);
         chk(ac(), 32'(tbl[i][6:0]));
      end
      wr(OFS_CTRL, 32'h0000_000D);
      u_host.cmd(OFS_INSTR, 32'h0000_0090);
      rd(OFS_DATA);
      chk({31'h0, e}, 32'h0000_0001);
      chk(q, 32'h0000_0000);
      chk(ac(), 32'h0000_0010);
      wr(OFS_CTRL, 32'h0000_0005);
      rd(8'h10);
      chk({31'h0, e}, 32'h0000_0001);
      wr(OFS_STATUS, 32'h0000_0000);
      chk({31'h0, e}, 32'h0000_0001);
      wr(OFS_CTRL, 32'h0000_0006);
      wr(OFS_INSTR, 32'h0000_007F);
      @(posedge pclk);
      presetn <= 1'b0;
      #1 chk({31'h0, busy_flag}, 32'h0000_0000);
      @(posedge pclk);
      presetn <= 1'b1;
      rd(OFS_STATUS);
      chk(q, 32'h0000_0000);
      rd(OFS_CTRL);
      chk(q, 32'h0000_0005);
      print_verdict();
   end
endmodule : lcdra_core_bench
`default_nettype wire
